//--- drps_pkg.sv
// package of constants and types for the drive ramp and pid supervisor
package drps_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h08;
    localparam logic [7:0] OFS_LOSS_CFG  = 8'h0C;
    localparam logic [7:0] OFS_SLEEP_CFG = 8'h10;
    localparam logic [7:0] OFS_WAKE_CFG  = 8'h14;
    localparam logic [7:0] OFS_ACCEL     = 8'h18;
    localparam logic [7:0] OFS_DECEL     = 8'h1C;
    localparam logic [7:0] OFS_SCURVE    = 8'h20;
    localparam logic [7:0] OFS_MOTOR     = 8'h24;
    localparam logic [7:0] OFS_PID_IN    = 8'h28;
    localparam logic [7:0] OFS_FREQ_REF  = 8'h2C;
    localparam logic [7:0] OFS_FREQ_OUT  = 8'h30;
    // status bit positions
    localparam int ST_LOSS  = 0;
    localparam int ST_SLEEP = 1;
    localparam int ST_WAKE  = 2;
    localparam int ST_FAULT = 3;
    // reset values (times in 0.1 s, freq in 0.01 Hz, percent in whole %)
    localparam logic [7:0]  RST_LOSS_TIME  = 8'h0A;
    localparam logic [7:0]  RST_SLEEP_DLY  = 8'h00;
    localparam logic [7:0]  RST_WAKE_DLY   = 8'h00;
    localparam logic [15:0] RST_ACC_DEC    = 16'h0064;
    localparam logic [7:0]  RST_SCURVE     = 8'h02;
    localparam logic [6:0]  RST_INT_LIMIT  = 7'h64;
    localparam logic [15:0] RST_RATED_FREQ = 16'h1388;
    localparam logic [15:0] RST_MAX_FREQ   = 16'h1388;
    localparam logic [7:0]  FN_ACC_DEC_TWO = 8'h1A;
    localparam logic [15:0] SCURVE_MAX     = 16'h0028;
    localparam logic [15:0] TIME_MIN       = 16'h0001;
    // control tick: 0.1 s at 50 MHz
    localparam int CLK_HZ       = 50_000_000;
    localparam int TICK_MS      = 100;
    localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
    typedef enum logic [1:0] {DRPS_RUN, DRPS_SLEEP} drps_mode_t;
endpackage

//--- drps_qual_if.sv
`timescale 1ns/1ps
// qualifier timer interface between the top and the timer block
interface drps_qual_if;
    logic       cond;
    logic [7:0] limit;
    logic       hit;
    modport owner (output cond, output limit, input hit);
    modport timer (input cond, input limit, output hit);
endinterface

//--- drps_qual_timer.sv
`timescale 1ns/1ps
// condition qualification timer counted in control ticks
module drps_qual_timer
    import drps_pkg::*;
(
    input  wire logic  i_mclk,
    input  wire logic  i_rst_b,
    input  wire logic  i_tick,
    drps_qual_if.timer q
);
    logic [7:0] cnt_reg;

    // restart from zero when the condition drops
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_reg <= 8'h00;
        end else if (!q.cond) begin
            cnt_reg <= 8'h00;
        end else if (i_tick && cnt_reg < q.limit) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // zero delay qualifies at once
    assign q.hit = q.cond && (cnt_reg >= q.limit);

    a_timer_restart: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !q.cond |=> cnt_reg == 8'h00) else $error("timer not restarted");
endmodule

//--- drps_top.sv
`timescale 1ns/1ps
// drive ramp, s-curve, slip, pid loss and sleep supervisor
module drps_top
    import drps_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_dig_in,
    input  wire logic [15:0] i_torque_pct,
    output logic      [15:0] o_out_freq,
    output logic             o_out_enable,
    output logic             o_loss_alarm,
    output logic             o_irq
);
    // synchronised multifunction input
    logic       din_s1_reg;
    logic       din_s2_reg;
    // registers
    logic [31:0] ctrl_reg;      // [0] run, [8:1] pid select, [16:9] analog fn, [24:17] din fn
    logic [3:0]  status_reg;
    logic [3:0]  mask_reg;
    logic [31:0] loss_cfg_reg;  // [6:0] level %, [14:7] time, [24:15] fb gain x0.01, [26:25] action
    logic [31:0] sleep_cfg_reg; // [15:0] freq, [23:16] delay, [30:24] integral limit %
    logic [31:0] wake_cfg_reg;  // [15:0] freq, [23:16] delay
    logic [31:0] accel_reg;     // [15:0] time one, [31:16] time two, 0.1 s
    logic [31:0] decel_reg;
    logic [31:0] scurve_reg;    // four bytes: acc start, acc end, dec start, dec end
    logic [31:0] motor_reg;     // [15:0] rated freq, [31:16] max freq
    logic [31:0] pid_in_reg;    // [15:0] target, [31:16] feedback, percent x0.01
    logic [31:0] freq_ref_reg;  // [15:0] reference, [31:16] pid output
    logic [11:0] slip_reg;      // slip gain in whole percent
    logic [31:0] integ_reg;
    logic [31:0] tick_cnt_reg;
    logic        tick_reg;
    logic [15:0] ramp_reg;
    logic [15:0] rate_reg;
    logic [7:0]  seg_cnt_reg;
    logic        fault_reg;
    drps_mode_t  mode_reg;
    logic        done_reg;
    logic        is_reg;
    logic [15:0] step_next;
    logic [15:0] target_freq;
    logic [15:0] t_sel;
    logic        use_two;
    logic        sleep_ok;
    logic [31:0] dev_scaled;
    logic [31:0] loss_lvl;
    logic [31:0] int_lim;
    logic [31:0] slip_add;
    logic [31:0] out_calc;
    logic        bus_sel;
    logic [31:0] rd_next;

    drps_qual_if loss_q ();
    drps_qual_if sleep_q ();
    drps_qual_if wake_q ();

    // two-stage synchroniser for the pin
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            din_s1_reg <= 1'b0;
            din_s2_reg <= 1'b0;
        end else begin
            din_s1_reg <= i_dig_in;
            din_s2_reg <= din_s1_reg;
        end
    end

    // control tick divider
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg >= 32'(TICK_LEN - 1)) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            tick_reg     <= 1'b0;
        end
    end

    // deviation and loss level in common units of 0.01 % x gain 0.01
    always_comb begin
        dev_scaled = 32'(signed'({1'b0, pid_in_reg[15:0]}) - signed'({1'b0, pid_in_reg[31:16]}));
        if (dev_scaled[31]) begin
            dev_scaled = 32'h0000_0000;
        end else begin
            dev_scaled = 32'(dev_scaled[16:0]) * 32'(loss_cfg_reg[24:15]);
        end
        // widened before the product so a full 100 % level is not cut short
        loss_lvl = 32'(loss_cfg_reg[6:0]) * 32'd10000;
    end

    assign loss_q.cond  = (loss_cfg_reg[26:25] != 2'b00) && (dev_scaled <= loss_lvl);
    assign loss_q.limit = loss_cfg_reg[14:7];
    assign sleep_ok     = (ctrl_reg[8:1] != 8'h00) && (ctrl_reg[16:9] == 8'h00);
    assign sleep_q.cond  = sleep_ok && mode_reg == DRPS_RUN && freq_ref_reg[31:16] <= sleep_cfg_reg[15:0];
    assign sleep_q.limit = sleep_cfg_reg[23:16];
    assign wake_q.cond   = mode_reg == DRPS_SLEEP && freq_ref_reg[31:16] >= wake_cfg_reg[15:0];
    assign wake_q.limit  = wake_cfg_reg[23:16];

    drps_qual_timer u_loss (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_tick(tick_reg), .q(loss_q));
    drps_qual_timer u_sleep (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_tick(tick_reg), .q(sleep_q));
    drps_qual_timer u_wake (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_tick(tick_reg), .q(wake_q));

    // sleep state machine
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mode_reg <= DRPS_RUN;
        end else begin
            unique case (mode_reg)
                DRPS_RUN: begin
                    if (sleep_q.hit) begin
                        mode_reg <= DRPS_SLEEP;
                    end
                end
                DRPS_SLEEP: begin
                    if (wake_q.hit || !sleep_ok) begin
                        mode_reg <= DRPS_RUN;
                    end
                end
                default: mode_reg <= DRPS_RUN;
            endcase
        end
    end

    // fault latch, cleared with its status bit
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fault_reg <= 1'b0;
        end else if (loss_q.hit && loss_cfg_reg[26:25] == 2'b10) begin
            fault_reg <= 1'b1;
        end else if (bus_sel && i_avs_write && i_avs_address == OFS_STATUS && i_avs_writedata[ST_FAULT]) begin
            fault_reg <= 1'b0;
        end
    end

    // integral term clamped to limit of max frequency
    assign int_lim = (32'(motor_reg[31:16]) * 32'(sleep_cfg_reg[30:24])) / 32'd100;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            integ_reg <= 32'h0000_0000;
        end else if (tick_reg) begin
            if (integ_reg + dev_scaled / 32'd10000 > int_lim) begin
                integ_reg <= int_lim;
            end else begin
                integ_reg <= integ_reg + dev_scaled / 32'd10000;
            end
        end
    end

    // ramp target and time set selection
    assign use_two     = din_s2_reg && ctrl_reg[24:17] == FN_ACC_DEC_TWO;
    assign target_freq = (ctrl_reg[0] && mode_reg == DRPS_RUN && !fault_reg) ? freq_ref_reg[15:0] : 16'h0000;
    always_comb begin
        if (target_freq >= ramp_reg) begin
            t_sel = use_two ? accel_reg[31:16] : accel_reg[15:0];
        end else begin
            t_sel = use_two ? decel_reg[31:16] : decel_reg[15:0];
        end
        if (t_sel < TIME_MIN) begin
            t_sel = TIME_MIN;
        end
    end

    // full-rate step per tick: rated frequency over time; s-curve halves it in the corner segments
    always_comb begin
        step_next = 16'(motor_reg[15:0] / t_sel);
        if (step_next == 16'h0000) begin
            step_next = 16'h0001;
        end
        if (seg_cnt_reg != 8'h00) begin
            step_next = (step_next >> 1) | 16'h0001;
        end
    end

    // ramp generator; s-curve start segment loads and counts down at each ramp start from a settled output
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ramp_reg    <= 16'h0000;
            rate_reg    <= 16'h0000;
            seg_cnt_reg <= 8'h00;
            done_reg    <= 1'b1;
            is_reg      <= 1'b0;
        end else if (tick_reg) begin
            rate_reg <= step_next;
            if (target_freq == ramp_reg) begin
                done_reg <= 1'b1;
            end else begin
                if (done_reg) begin
                    is_reg      <= target_freq > ramp_reg;
                    seg_cnt_reg <= target_freq > ramp_reg ? scurve_reg[7:0] : scurve_reg[23:16];
                end else if (seg_cnt_reg != 8'h00) begin
                    seg_cnt_reg <= seg_cnt_reg - 8'h01;
                end else if (is_reg && target_freq - ramp_reg <= 16'(step_next * scurve_reg[15:8])) begin
                    seg_cnt_reg <= scurve_reg[15:8];
                end else if (!is_reg && ramp_reg - target_freq <= 16'(step_next * scurve_reg[31:24])) begin
                    seg_cnt_reg <= scurve_reg[31:24];
                end
                done_reg <= 1'b0;
                if (target_freq > ramp_reg) begin
                    ramp_reg <= (target_freq - ramp_reg > step_next) ? ramp_reg + step_next : target_freq;
                end else begin
                    ramp_reg <= (ramp_reg - target_freq > step_next) ? ramp_reg - step_next : target_freq;
                end
            end
        end
    end

    // slip: rated frequency share scaled by torque and gain
    // gain is held in whole percent, so rated x torque % x gain % over 1e4
    assign slip_add = (({16'h0000, motor_reg[15:0]} * 32'(i_torque_pct) / 32'd100) * 32'(slip_reg)) / 32'd100;
    assign out_calc = {16'h0000, ramp_reg} + (ramp_reg == 16'h0000 ? 32'h0000_0000 : slip_add);

    // outputs to the power stage
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_out_freq   <= 16'h0000;
            o_out_enable <= 1'b0;
            o_loss_alarm <= 1'b0;
        end else begin
            o_out_freq   <= out_calc > 32'h0000_FFFF ? 16'hFFFF : out_calc[15:0];
            o_out_enable <= mode_reg == DRPS_RUN && !fault_reg && ctrl_reg[0];
            o_loss_alarm <= loss_q.hit;
        end
    end

    // sticky status, set wins over write-one clear
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            status_reg <= 4'h0;
        end else begin
            for (int b = 0; b < 4; b++) begin
                if (bus_sel && i_avs_write && i_avs_address == OFS_STATUS && i_avs_writedata[b]) begin
                    status_reg[b] <= 1'b0;
                end
            end
            if (loss_q.hit) status_reg[ST_LOSS] <= 1'b1;
            if (sleep_q.hit) status_reg[ST_SLEEP] <= 1'b1;
            if (wake_q.hit) status_reg[ST_WAKE] <= 1'b1;
            if (loss_q.hit && loss_cfg_reg[26:25] == 2'b10) status_reg[ST_FAULT] <= 1'b1;
        end
    end

    // avalon slave: one wait cycle then answer
    assign bus_sel = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
        end else begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
            o_avs_readdata    <= rd_next;
        end
    end

    always_comb begin
        unique case (i_avs_address)
            OFS_CTRL:      rd_next = {7'h00, ctrl_reg[24:0]};
            OFS_STATUS:    rd_next = {27'h0, mode_reg == DRPS_SLEEP, status_reg};
            OFS_IRQ_MASK:  rd_next = {28'h0, mask_reg};
            OFS_LOSS_CFG:  rd_next = {5'h00, loss_cfg_reg[26:0]};
            OFS_SLEEP_CFG: rd_next = {1'b0, sleep_cfg_reg[30:0]};
            OFS_WAKE_CFG:  rd_next = {8'h00, wake_cfg_reg[23:0]};
            OFS_ACCEL:     rd_next = accel_reg;
            OFS_DECEL:     rd_next = decel_reg;
            OFS_SCURVE:    rd_next = scurve_reg;
            OFS_MOTOR:     rd_next = motor_reg;
            OFS_PID_IN:    rd_next = pid_in_reg;
            OFS_FREQ_REF:  rd_next = freq_ref_reg;
            OFS_FREQ_OUT:  rd_next = {4'h0, slip_reg, o_out_freq};
            default:       rd_next = 32'h0000_0000;
        endcase
    end

    // register writes, byte lanes honoured
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctrl_reg      <= 32'h0000_0000;
            mask_reg      <= 4'h0;
            loss_cfg_reg  <= {5'h00, 2'b00, 10'd100, RST_LOSS_TIME, 7'h00};
            sleep_cfg_reg <= {1'b0, RST_INT_LIMIT, RST_SLEEP_DLY, 16'h0000};
            wake_cfg_reg  <= {8'h00, RST_WAKE_DLY, 16'h0000};
            accel_reg     <= {RST_ACC_DEC, RST_ACC_DEC};
            decel_reg     <= {RST_ACC_DEC, RST_ACC_DEC};
            scurve_reg    <= {4{RST_SCURVE}};
            motor_reg     <= {RST_MAX_FREQ, RST_RATED_FREQ};
            pid_in_reg    <= 32'h0000_0000;
            freq_ref_reg  <= 32'h0000_0000;
            slip_reg      <= 12'h000;
        end else if (bus_sel && i_avs_write) begin
            for (int b = 0; b < 4; b++) begin
                if (i_avs_byteenable[b]) begin
                    unique case (i_avs_address)
                        OFS_CTRL:      ctrl_reg[8*b +: 8]      <= i_avs_writedata[8*b +: 8];
                        OFS_IRQ_MASK:  if (b == 0) mask_reg <= i_avs_writedata[3:0];
                        OFS_LOSS_CFG:  loss_cfg_reg[8*b +: 8]  <= i_avs_writedata[8*b +: 8];
                        OFS_SLEEP_CFG: sleep_cfg_reg[8*b +: 8] <= i_avs_writedata[8*b +: 8];
                        OFS_WAKE_CFG:  wake_cfg_reg[8*b +: 8]  <= i_avs_writedata[8*b +: 8];
                        OFS_ACCEL:     accel_reg[8*b +: 8]     <= i_avs_writedata[8*b +: 8];
                        OFS_DECEL:     decel_reg[8*b +: 8]     <= i_avs_writedata[8*b +: 8];
                        OFS_SCURVE:    scurve_reg[8*b +: 8]    <= i_avs_writedata[8*b +: 8];
                        OFS_MOTOR:     motor_reg[8*b +: 8]     <= i_avs_writedata[8*b +: 8];
                        OFS_PID_IN:    pid_in_reg[8*b +: 8]    <= i_avs_writedata[8*b +: 8];
                        OFS_FREQ_REF:  freq_ref_reg[8*b +: 8]  <= i_avs_writedata[8*b +: 8];
                        OFS_FREQ_OUT:  if (b == 2) slip_reg <= {4'h0, i_avs_writedata[23:16]};
                        default: ;
                    endcase
                end
            end
        end
    end

    // one level interrupt from unmasked sticky bits
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status_reg & mask_reg);
        end
    end

    // checks
    a_loss_fault_off: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        fault_reg |=> !o_out_enable) else $error("output on during fault");
    a_sleep_output_off: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        mode_reg == DRPS_SLEEP |=> !o_out_enable) else $error("output on while asleep");
    a_sleep_needs_pid: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(mode_reg == DRPS_SLEEP) |-> $past(sleep_ok)) else $error("sleep without pid");
    a_wake_needs_hit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (mode_reg == DRPS_SLEEP && sleep_ok && !wake_q.hit) |=> mode_reg == DRPS_SLEEP) else $error("early wake");
    a_ramp_step_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !tick_reg |=> $stable(ramp_reg)) else $error("ramp moved off tick");
    a_ramp_up_limit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        tick_reg && target_freq > ramp_reg |=> ramp_reg > $past(ramp_reg) && ramp_reg <= $past(target_freq))
        else $error("ramp up wrong");
    a_ramp_down_limit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        tick_reg && target_freq < ramp_reg |=> ramp_reg < $past(ramp_reg) && ramp_reg >= $past(target_freq))
        else $error("ramp down wrong");
    a_integral_clamp: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        tick_reg |=> integ_reg <= $past(int_lim)) else $error("integral over limit");
    a_set_two_select: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        use_two && target_freq > ramp_reg |-> t_sel == (accel_reg[31:16] < TIME_MIN ? TIME_MIN : accel_reg[31:16]))
        else $error("time set two not used");
    a_alarm_follows: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        loss_q.hit |=> o_loss_alarm && status_reg[ST_LOSS]) else $error("loss flag missing");

    c_sleep_entry: cover property (@(posedge i_mclk) disable iff (!i_rst_b) $rose(mode_reg == DRPS_SLEEP));
    c_wake_up: cover property (@(posedge i_mclk) disable iff (!i_rst_b) $fell(mode_reg == DRPS_SLEEP));
    c_fault_trip: cover property (@(posedge i_mclk) disable iff (!i_rst_b) $rose(fault_reg));
    c_scurve_run: cover property (@(posedge i_mclk) disable iff (!i_rst_b) seg_cnt_reg != 8'h00 && tick_reg);
endmodule

//--- drps_stage_model.sv
`timescale 1ns/1ps
// behavioural power stage and motor load for the supervisor bench
module drps_stage_model (
    input  wire logic        i_mclk,
    input  wire logic        i_enable,
    input  wire logic [15:0] i_load_pct,
    output logic      [15:0] o_torque_pct
);
    // a stopped stage draws no torque, so slip must not add anything then
    always_ff @(posedge i_mclk) begin
        o_torque_pct <= i_enable ? i_load_pct : 16'h0000;
    end
endmodule

//--- drps_top_tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the drive ramp and pid supervisor
module drps_top_tb_top;
    import drps_pkg::*;
    localparam int TL = 20;
    logic i_mclk = 1'b0, i_rst_b = 1'b0, rd = 1'b0, wr = 1'b0, dig = 1'b0, wt, en, alarm, irq;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdat, q;
    logic [15:0] load = 16'h0000, torque, fout;
    int fails = 0, checks_done = 0, cyc = 0;
    drps_top #(.TICK_LEN(TL)) drps_top_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .i_dig_in(dig), .i_torque_pct(torque),
        .o_out_freq(fout), .o_out_enable(en), .o_loss_alarm(alarm), .o_irq(irq));
    drps_stage_model drps_stage_model_i (.i_mclk(i_mclk), .i_enable(en), .i_load_pct(load),
        .o_torque_pct(torque));
    initial begin
        forever #10 i_mclk = ~i_mclk;
    end
    // hang guard sized well above the planned run
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do @(posedge i_mclk); while (wt !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic ticks(input int n);
        repeat (n * TL) @(posedge i_mclk);
        #1;
    endtask
    initial begin
        repeat (20) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        bus(0, OFS_LOSS_CFG, 0); chk("loss cfg", q, 32'h0032_0500);
        bus(0, OFS_ACCEL, 0); chk("accel", q, 32'h0064_0064);
        bus(0, OFS_SCURVE, 0); chk("scurve", q, 32'h0202_0202);
        bus(0, 8'h3C, 0); chk("unmapped", q, 32'h0000_0000);
        $display("test reset values done");
        bus(1, OFS_SCURVE, 0);
        bus(1, OFS_ACCEL, 32'h0002_000A);
        bus(1, OFS_DECEL, 32'h0002_000A);
        bus(1, OFS_CTRL, 32'h0034_0001);
        bus(1, OFS_FREQ_REF, 32'h0000_1388);
        ticks(5); chk("half ramp", {16'h0, fout} < 32'h1388, 1);
        ticks(6); chk("accel end", fout, 16'h1388);
        bus(1, OFS_FREQ_REF, 32'h0000_09C4);
        ticks(6); chk("decel ref", fout, 16'h09C4);
        bus(1, OFS_FREQ_REF, 32'h0000_0000);
        ticks(6); chk("decel end", fout, 16'h0000);
        dig <= 1'b1;
        bus(1, OFS_FREQ_REF, 32'h0000_1388);
        ticks(3); chk("set two", fout, 16'h1388);
        $display("test ramp done");
        load <= 16'h000A;
        bus(1, OFS_FREQ_OUT, 32'h0064_0000);
        ticks(3); chk("slip", fout, 16'h157C);
        load <= 16'h0000;
        $display("test slip done");
        bus(1, OFS_IRQ_MASK, 32'h0000_0002);
        bus(1, OFS_WAKE_CFG, 32'h0001_07D0);
        bus(1, OFS_SLEEP_CFG, 32'h6402_03E8);
        bus(1, OFS_FREQ_REF, 32'h01F4_1388);
        bus(1, OFS_CTRL, 32'h0034_0003);
        ticks(1); chk("sleep early", en, 1'b1);
        ticks(3); chk("asleep", en, 1'b0);
        chk("irq set", irq, 1'b1);
        bus(1, OFS_STATUS, 32'h0000_0002);
        @(posedge i_mclk);
        #1; chk("irq clear", irq, 1'b0);
        bus(1, OFS_FREQ_REF, 32'h0BB8_1388);
        ticks(3); chk("awake", en, 1'b1);
        bus(0, OFS_STATUS, 0); chk("wake flag", q[2], 1'b1);
        $display("test sleep done");
        bus(1, OFS_PID_IN, 32'h1388_1388);
        bus(1, OFS_LOSS_CFG, 32'h0232_010A);
        ticks(4); chk("loss alarm", alarm, 1'b1);
        chk("alarm runs", en, 1'b1);
        $display("test loss done");
        wrap_up();
    end
endmodule
